// [core/uirp_defines.svh]
// Register address, reset values, pin positions and frame constants of the infrared UART block
`ifndef UIRP_DEFINES_SVH
`define UIRP_DEFINES_SVH

`define UIRP_PORT2_DIR_ADDR   16'hff22
`define UIRP_PORT2_DIR_RESET  8'hff
`define UIRP_PORT2_DIR_FIXED  8'hc0
`define UIRP_UNMAPPED_RDATA   8'h00

`define UIRP_EXT_CLK_PIN      3'h5
`define UIRP_TX_PIN           3'h4
`define UIRP_RX_PIN           3'h3

`define UIRP_SRC_SEL_MSB      6
`define UIRP_SRC_SEL_LSB      4
`define UIRP_DIV_CODE_MSB     3
`define UIRP_DIV_CODE_LSB     0

`define UIRP_FRAME_LAST_BIT   4'h9
`define UIRP_START_BIT        4'h0
`define UIRP_TX_IDLE_UART     1'h1
`define UIRP_TX_IDLE_IR       1'h0

`endif

// [core/uirp_pkg.sv]
// Types shared by the infrared UART block
package uirp_pkg;

  typedef struct packed {
    logic infrared_select;
    logic transmit_enable_bit;
    logic receive_enable_bit;
  } uirp_mode_t;

  typedef struct packed {
    logic [7:0] data;
    logic       frame_err;
  } uirp_rx_t;

  typedef enum logic [1:0] {
    UIRP_TX_IDLE = 2'h1,
    UIRP_TX_RUN  = 2'h2
  } uirp_tx_state_t;

  typedef enum logic [1:0] {
    UIRP_RX_IDLE = 2'h1,
    UIRP_RX_RUN  = 2'h2
  } uirp_rx_state_t;

endpackage : uirp_pkg

// [core/uirp_top.sv]
// Infrared / plain UART serial unit with port 2 direction register and pin routing
//
// How it works
// (RULE1) Direction bit 0 drives the pin, 1 releases it; bits 7:6 read 1.
// (RULE2) Reset loads the direction register with all ones, every pin input.
// (RULE3) Software clears tx pin direction bit and latch before transmitting.
// (RULE4) Software sets rx and external clock pin direction bits to input.
// (RULE5) A frame is start bit, eight data bits, stop bit, LSB first.
// (RULE6) Infrared pulses last three sixteenths of a bit, received likewise.
// (RULE7) The infrared pulse starts at the middle of its bit period.
// (RULE8) Software sets the generator control to 10h for infrared mode.
// (RULE9) With 10h the bit rate is the system clock divided by 64.
// (RULE10) Rate stays exact; received pulses are checked against a width window.
// (RULE11) Infrared receive bits are taken half a bit after the pulse point.
// (RULE12) Both enables clear stops the unit; pins become plain port pins.
// (RULE13) Infrared select picks signalling; enables pick the active directions.
// (RULE14) Source is clock over 2^n; divider makes 16 plus k source ticks.
// (RULE15) Infrared transmit idles low and pulses only for zero bits.
// (RULE16) Infrared receive decodes pulse as zero and no pulse as one.
`timescale 1ns/10ps
`include "uirp_defines.svh"

module uirp_top (
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic [15:0]          reg_addr_in,
  input  wire logic [7:0]           reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output logic [7:0]                reg_rdata_out,
  input  wire uirp_pkg::uirp_mode_t mode_in,
  input  wire logic [6:0]           baud_gen_control_in,
  input  wire logic [5:0]           port_latch_in,
  input  wire logic [5:0]           pin_in,
  output logic [5:0]                pin_out,
  output logic [5:0]                pin_oe_n_out,
  input  wire logic                 tx_valid_in,
  input  wire logic [7:0]           tx_data_in,
  output logic                      tx_ready_out,
  output uirp_pkg::uirp_rx_t        rx_word_out,
  output logic                      rx_valid_out
);

  // Bit period in source ticks: two generator periods of 16 + k ticks
  function automatic logic [5:0] bit_len(input logic [3:0] k);
    bit_len = {1'b1, k, 1'b0};
  endfunction : bit_len

  // num sixteenths of a bit period, rounded down
  function automatic logic [5:0] frac16(input logic [5:0] len, input logic [2:0] num);
    logic [8:0] prod;
    prod = 9'(len) * 9'(num);
    frac16 = {1'b0, prod[8:4]};
  endfunction : frac16

  // Prescaler mask for source division by 2^n
  function automatic logic [6:0] tick_mask(input logic [2:0] n);
    tick_mask = 7'h7f >> (3'h7 - n);
  endfunction : tick_mask

  logic [7:0]                dir_q;
  logic [7:0]                rdata_q;
  logic [5:0]                sync1_q;
  logic [5:0]                sync2_q;
  logic [5:0]                prev_q;
  logic [6:0]                pre_q;
  logic                      src_tick;
  logic [2:0]                src_sel;
  logic [3:0]                div_code;
  logic [5:0]                blen;
  logic [5:0]                half;
  logic [5:0]                plen;
  uirp_pkg::uirp_tx_state_t  tx_state_q;
  logic [9:0]                tx_shift_q;
  logic [3:0]                tx_bit_q;
  logic [5:0]                tx_cnt_q;
  logic                      tx_ready_q;
  logic                      tx_take;
  logic                      tx_level;
  logic [5:0]                pin_out_q;
  logic [5:0]                pin_oe_n_q;
  uirp_pkg::uirp_rx_state_t  rx_state_q;
  logic [5:0]                rx_cnt_q;
  logic [3:0]                rx_bit_q;
  logic [7:0]                rx_shift_q;
  logic                      seen_q;
  logic [5:0]                hi_cnt_q;
  logic                      rx_pin;
  logic                      rx_rise;
  logic                      rx_fall;
  logic                      pulse_ok;
  logic                      rx_bitv;
  uirp_pkg::uirp_rx_t        rx_word_q;
  logic                      rx_valid_q;

  assign src_sel  = baud_gen_control_in[`UIRP_SRC_SEL_MSB:`UIRP_SRC_SEL_LSB];
  assign div_code = baud_gen_control_in[`UIRP_DIV_CODE_MSB:`UIRP_DIV_CODE_LSB];
  assign blen     = bit_len(div_code); // RULE14
  assign half     = blen >> 1; // RULE7
  assign plen     = frac16(blen, 3'h3); // RULE6

  // Direction register write and read port
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dir_q <= `UIRP_PORT2_DIR_RESET; // RULE2
    end else if (reg_wr_in && reg_addr_in == `UIRP_PORT2_DIR_ADDR) begin
      dir_q <= reg_wdata_in | `UIRP_PORT2_DIR_FIXED; // RULE1
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= `UIRP_UNMAPPED_RDATA;
    end else if (reg_rd_in) begin
      rdata_q <= (reg_addr_in == `UIRP_PORT2_DIR_ADDR) ? dir_q : `UIRP_UNMAPPED_RDATA;
    end
  end

  // Pin input synchronisers
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
      prev_q  <= 6'h00;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Baud source: external clock rising edge or system clock over 2^n
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_q <= 7'h00;
    end else begin
      pre_q <= pre_q + 7'h01;
    end
  end

  assign src_tick = (src_sel == 3'h0) ?
                    (sync2_q[`UIRP_EXT_CLK_PIN] && !prev_q[`UIRP_EXT_CLK_PIN]) :
                    ((pre_q & tick_mask(src_sel)) == tick_mask(src_sel)); // RULE14 RULE9

  // Transmitter
  assign tx_take = tx_valid_in && tx_ready_q;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_state_q <= uirp_pkg::UIRP_TX_IDLE;
      tx_shift_q <= 10'h3ff;
      tx_bit_q   <= 4'h0;
      tx_cnt_q   <= 6'h00;
      tx_ready_q <= 1'b0;
    end else begin
      case (tx_state_q)
        uirp_pkg::UIRP_TX_IDLE: begin
          tx_ready_q <= mode_in.transmit_enable_bit && !tx_take; // RULE13
          if (tx_take) begin
            tx_shift_q <= {1'b1, tx_data_in, 1'b0}; // RULE5
            tx_bit_q   <= 4'h0;
            tx_cnt_q   <= 6'h00;
            tx_state_q <= uirp_pkg::UIRP_TX_RUN;
          end
        end
        uirp_pkg::UIRP_TX_RUN: begin
          tx_ready_q <= 1'b0;
          if (!mode_in.transmit_enable_bit) begin
            tx_state_q <= uirp_pkg::UIRP_TX_IDLE;
          end else if (src_tick) begin
            if (tx_cnt_q == blen - 6'h01) begin
              tx_cnt_q   <= 6'h00;
              tx_shift_q <= {1'b1, tx_shift_q[9:1]};
              tx_bit_q   <= tx_bit_q + 4'h1;
              if (tx_bit_q == `UIRP_FRAME_LAST_BIT) begin // RULE5
                tx_state_q <= uirp_pkg::UIRP_TX_IDLE;
              end
            end else begin
              tx_cnt_q <= tx_cnt_q + 6'h01;
            end
          end
        end
        default: begin
          tx_state_q <= uirp_pkg::UIRP_TX_IDLE;
          tx_ready_q <= 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    if (mode_in.infrared_select) begin
      tx_level = (tx_state_q == uirp_pkg::UIRP_TX_RUN) && !tx_shift_q[0] && // RULE15
                 (tx_cnt_q >= half) && (tx_cnt_q < half + plen); // RULE6 RULE7
    end else begin
      tx_level = (tx_state_q == uirp_pkg::UIRP_TX_RUN) ? tx_shift_q[0] : `UIRP_TX_IDLE_UART;
    end
  end

  // Pin routing: buffers follow the direction bits, tx pin carries data when enabled
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_out_q  <= 6'h00;
      pin_oe_n_q <= 6'h3f;
    end else begin
      pin_oe_n_q <= dir_q[5:0]; // RULE1
      pin_out_q  <= port_latch_in; // RULE12
      if (mode_in.transmit_enable_bit) begin
        pin_out_q[`UIRP_TX_PIN] <= tx_level; // RULE3
      end
    end
  end

  // Receiver
  assign rx_pin   = sync2_q[`UIRP_RX_PIN]; // RULE4
  assign rx_rise  = rx_pin && !prev_q[`UIRP_RX_PIN];
  assign rx_fall  = !rx_pin && prev_q[`UIRP_RX_PIN];
  assign pulse_ok = rx_fall && (hi_cnt_q >= (blen >> 3)) &&
                    (hi_cnt_q <= frac16(blen, 3'h5)); // RULE10 RULE6
  assign rx_bitv  = mode_in.infrared_select ? !seen_q : seen_q; // RULE16

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hi_cnt_q <= 6'h00;
    end else if (!rx_pin) begin
      hi_cnt_q <= 6'h00;
    end else if (src_tick && hi_cnt_q != 6'h3f) begin
      hi_cnt_q <= hi_cnt_q + 6'h01;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_state_q <= uirp_pkg::UIRP_RX_IDLE;
      rx_cnt_q   <= 6'h00;
      rx_bit_q   <= 4'h0;
      rx_shift_q <= 8'h00;
      seen_q     <= 1'b0;
      rx_word_q  <= '0;
      rx_valid_q <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      case (rx_state_q)
        uirp_pkg::UIRP_RX_IDLE: begin
          seen_q   <= 1'b0;
          rx_bit_q <= `UIRP_START_BIT;
          if (mode_in.receive_enable_bit &&
              (mode_in.infrared_select ? rx_rise : rx_fall)) begin // RULE13
            rx_cnt_q   <= mode_in.infrared_select ? half : 6'h00; // RULE11
            rx_state_q <= uirp_pkg::UIRP_RX_RUN;
          end
        end
        uirp_pkg::UIRP_RX_RUN: begin
          if (!mode_in.receive_enable_bit) begin
            rx_state_q <= uirp_pkg::UIRP_RX_IDLE;
          end else begin
            if (src_tick && rx_cnt_q == blen - 6'h01) begin
              rx_cnt_q <= 6'h00;
              seen_q   <= 1'b0;
              rx_bit_q <= rx_bit_q + 4'h1;
              if (rx_bit_q == `UIRP_START_BIT && rx_bitv) begin
                rx_state_q <= uirp_pkg::UIRP_RX_IDLE;
              end else if (rx_bit_q == `UIRP_FRAME_LAST_BIT) begin // RULE5
                rx_word_q.data      <= rx_shift_q;
                rx_word_q.frame_err <= !rx_bitv;
                rx_valid_q          <= 1'b1;
                rx_state_q          <= uirp_pkg::UIRP_RX_IDLE;
              end else if (rx_bit_q != `UIRP_START_BIT) begin
                rx_shift_q <= {rx_bitv, rx_shift_q[7:1]};
              end
            end else if (src_tick) begin
              rx_cnt_q <= rx_cnt_q + 6'h01;
              if (!mode_in.infrared_select && rx_cnt_q == half) begin
                seen_q <= rx_pin;
              end
            end
            if (mode_in.infrared_select && pulse_ok) begin
              seen_q <= 1'b1; // RULE16
            end
          end
        end
        default: begin
          rx_state_q <= uirp_pkg::UIRP_RX_IDLE;
        end
      endcase
    end
  end

  assign reg_rdata_out = rdata_q;
  assign pin_out       = pin_out_q;
  assign pin_oe_n_out  = pin_oe_n_q;
  assign tx_ready_out  = tx_ready_q;
  assign rx_word_out   = rx_word_q;
  assign rx_valid_out  = rx_valid_q;

endmodule : uirp_top

// [dv/uirp_properties.sv]
// Concurrent checks on the infrared UART block ports
`timescale 1ns/10ps
module uirp_properties (
  input wire logic                 sys_clk_in,
  input wire logic                 rst_n_in,
  input wire logic [15:0]          reg_addr_in,
  input wire logic [7:0]           reg_wdata_in,
  input wire logic                 reg_wr_in,
  input wire logic                 reg_rd_in,
  input wire logic [7:0]           reg_rdata_out,
  input wire uirp_pkg::uirp_mode_t mode_in,
  input wire logic [6:0]           baud_gen_control_in,
  input wire logic [5:0]           port_latch_in,
  input wire logic [5:0]           pin_out,
  input wire logic [5:0]           pin_oe_n_out,
  input wire logic                 tx_valid_in,
  input wire logic                 tx_ready_out
);
  logic       ir_tx;
  logic       dir_wr;
  logic [4:0] hi_q;
  logic [9:0] busy_q;
  assign ir_tx = mode_in.infrared_select && mode_in.transmit_enable_bit;
  assign dir_wr = reg_wr_in && reg_addr_in == 16'hff22;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Length of the current high run on the transmit pin in infrared mode
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) hi_q <= 5'h00;
    else hi_q <= (ir_tx && pin_out[4]) ? hi_q + 5'h01 : 5'h00;
  end
  // Cycles from a taken byte until the transmitter is ready again
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) busy_q <= 10'h000;
    else if (tx_valid_in && tx_ready_out) busy_q <= 10'h001;
    else if (tx_ready_out) busy_q <= 10'h000;
    else if (busy_q != 10'h000) busy_q <= busy_q + 10'h001;
  end
  dir_reset_a: assert property ($rose(rst_n_in) |-> pin_oe_n_out == 6'h3f)
    else $error("direction outputs not all input after reset");
  fixed_bits_a: assert property (
    reg_rd_in && reg_addr_in == 16'hff22 |=> reg_rdata_out[7:6] == 2'b11)
    else $error("upper direction bits did not read as one");
  dir_to_pins_a: assert property (
    dir_wr |=> ##1 {2'b00, pin_oe_n_out} == ($past(reg_wdata_in, 2) & 8'h3f))
    else $error("output buffers do not follow the written direction");
  take_drop_a: assert property (tx_valid_in && tx_ready_out |=> !tx_ready_out)
    else $error("transmitter still ready after taking a byte");
  frame_len_a: assert property (
    $rose(tx_ready_out) && busy_q != 10'h000 && baud_gen_control_in == 7'h10
    |-> busy_q >= 10'h27f && busy_q <= 10'h283)
    else $error("frame length is not ten bits of sixty-four clocks");
  pulse_width_a: assert property (
    $fell(pin_out[4]) && ir_tx && baud_gen_control_in == 7'h10 |-> hi_q == 5'h0c)
    else $error("infrared pulse is not twelve clocks wide");
  ir_idle_low_a: assert property (
    ir_tx && $past(ir_tx) && tx_ready_out && $past(tx_ready_out) |-> !pin_out[4])
    else $error("infrared transmit line not low while idle");
  uart_idle_a: assert property (
    !mode_in.infrared_select && !$past(mode_in.infrared_select)
    && !$past(mode_in.infrared_select, 2) && tx_ready_out && $past(tx_ready_out)
    |-> pin_out[4])
    else $error("plain serial transmit line not high while idle");
  stop_latch_a: assert property (
    !mode_in.transmit_enable_bit && !$past(mode_in.transmit_enable_bit)
    |=> pin_out[4] == $past(port_latch_in[4]))
    else $error("stopped transmit pin does not show the port latch");
endmodule : uirp_properties

// [dv/uirp_ir_peer.sv]
// Infrared transceiver model: sends pulse frames and decodes the block's pulses
`timescale 1ns/10ps
module uirp_ir_peer #(
  parameter int BIT_CLKS = 64
) (
  input  wire logic sys_clk_in,
  input  wire logic line_in,
  output logic       line_out,
  output logic [9:0] frame_out,
  output int         width_out
);
  initial line_out = 1'b0;
  // Parks the line at a fixed level between frames
  task automatic hold(input logic lvl);
    line_out = lvl;
  endtask : hold
  // Samples each later bit slot in the middle of where its pulse would be
  initial forever begin
    @(negedge sys_clk_in iff line_in === 1'b1);
    width_out = 0;
    while (line_in === 1'b1) begin
      width_out++;
      @(negedge sys_clk_in);
    end
    frame_out[0] = 1'b0;
    for (int i = 1; i < 10; i++) begin
      repeat (i == 1 ? BIT_CLKS + 6 - width_out : BIT_CLKS) @(negedge sys_clk_in);
      frame_out[i] = !line_in;
    end
  end
  // Idle slot, start bit, data LSB first, stop bit; pulse or plain level
  task automatic send(input logic [7:0] d, input logic stop, input logic ir);
    logic [10:0] f;
    logic        pulse;
    f = {stop, d, 2'b01};
    for (int i = 0; i < 11; i++) begin
      for (int c = 0; c < BIT_CLKS; c++) begin
        @(posedge sys_clk_in);
        #1;
        pulse = c >= BIT_CLKS / 2 && c < BIT_CLKS / 2 + 3 * BIT_CLKS / 16;
        line_out = ir ? (!f[i] && pulse) : f[i];
      end
    end
  endtask : send
endmodule : uirp_ir_peer

// [dv/tb.sv]
// Self-checking bench: port 2 direction register, pin routing and infrared frames
`timescale 1ns/10ps
module tb;
  logic                 sys_clk_in, rst_n_in, reg_wr_in, reg_rd_in, tx_valid_in;
  logic                 tx_ready_out, rx_valid_out, rx_line, ext_clk;
  logic [15:0]          reg_addr_in;
  logic [7:0]           reg_wdata_in, reg_rdata_out, tx_data_in;
  logic [6:0]           baud_gen_control_in;
  logic [5:0]           port_latch_in, pin_out, pin_oe_n_out;
  logic [9:0]           peer_frame;
  uirp_pkg::uirp_mode_t mode_in;
  uirp_pkg::uirp_rx_t   rx_word_out;
  int                   peer_width, mismatches, checked, n;
  uirp_top DUT (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .mode_in(mode_in), .port_latch_in(port_latch_in),
    .baud_gen_control_in(baud_gen_control_in), .pin_in({ext_clk, 1'b0, rx_line, 3'b000}),
    .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out), .tx_valid_in(tx_valid_in),
    .tx_data_in(tx_data_in), .tx_ready_out(tx_ready_out), .rx_word_out(rx_word_out),
    .rx_valid_out(rx_valid_out));
  uirp_ir_peer ir_peer (.sys_clk_in(sys_clk_in), .line_in(pin_out[4]), .line_out(rx_line),
    .frame_out(peer_frame), .width_out(peer_width));
  task tick;
    @(posedge sys_clk_in);
    #1;
  endtask : tick
  task check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    tick;
    reg_wr_in = 1'b0;
  endtask : wr
  task rd(input logic [15:0] a, output logic [7:0] d);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    tick;
    reg_rd_in = 1'b0;
    tick;
    d = reg_rdata_out;
  endtask : rd
  task automatic rx_frame(input logic [7:0] d, input logic stop, ir, input logic [8:0] exp);
    fork
      ir_peer.send(d, stop, ir);
      @(posedge sys_clk_in iff rx_valid_out === 1'b1);
    join
    check("received word", rx_word_out, exp);
    #1;
  endtask : rx_frame
  task conclude;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  // External baud clock: one rising edge every two system clocks
  initial begin
    ext_clk = 1'b0;
    forever begin
      tick;
      ext_clk = ~ext_clk;
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    mismatches++;
    conclude;
  end
  initial begin
    logic [7:0] v;
    {rst_n_in, reg_wr_in, reg_rd_in, tx_valid_in} = 4'h0;
    {reg_addr_in, reg_wdata_in, tx_data_in} = 32'h0000_0000;
    mode_in = 3'h0;
    baud_gen_control_in = 7'h10;
    port_latch_in = 6'h3a;
    repeat (6) @(posedge sys_clk_in);
    #1;
    rst_n_in = 1'b1;
    rd(16'hff22, v);
    check("direction after reset", v, 9'h0ff);
    check("buffers after reset", pin_oe_n_out, 9'h03f);
    wr(16'hff22, 8'h00);
    rd(16'hff22, v);
    check("direction readback", v, 9'h0c0);
    check("buffers on", pin_oe_n_out, 9'h000);
    wr(16'hff21, 8'hff);
    rd(16'hff22, v);
    check("direction kept", v, 9'h0c0);
    rd(16'hff21, v);
    check("unmapped read", v, 9'h000);
    wr(16'hff22, 8'h28);
    rd(16'hff22, v);
    check("serial direction", v, 9'h0e8);
    check("serial buffers", pin_oe_n_out, 9'h028);
    check("stopped pins", pin_out, 9'h03a);
    port_latch_in = 6'h00;
    // Let the peer finish decoding the long latch-high run on the transmit pin
    repeat (600) tick;
    mode_in = 3'h7;
    tx_data_in = 8'h5a;
    tx_valid_in = 1'b1;
    @(posedge sys_clk_in iff tx_ready_out === 1'b1);
    #1;
    tx_valid_in = 1'b0;
    n = 0;
    while (pin_out[4] !== 1'b1 && n < 100) begin
      tick;
      n++;
    end
    check("pulse start", 9'(n >= 32 && n <= 35), 9'h001);
    @(posedge sys_clk_in iff tx_ready_out === 1'b1);
    check("infrared frame", peer_frame[9:1], {1'b1, 8'h5a});
    check("pulse width", 9'(peer_width), 9'h00c);
    rx_frame(8'ha5, 1'b1, 1'b1, 9'h14a);
    rx_frame(8'h3c, 1'b0, 1'b1, 9'h079);
    mode_in = 3'h3;
    repeat (4) tick;
    ir_peer.hold(1'b1);
    repeat (4) tick;
    rx_frame(8'hc3, 1'b1, 1'b0, 9'h186);
    baud_gen_control_in = 7'h00;
    repeat (4) tick;
    rx_frame(8'h96, 1'b1, 1'b0, 9'h12c);
    conclude;
  end
endmodule : tb
bind uirp_top uirp_properties chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .mode_in(mode_in),
  .baud_gen_control_in(baud_gen_control_in), .port_latch_in(port_latch_in),
  .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out), .tx_valid_in(tx_valid_in),
  .tx_ready_out(tx_ready_out));
